// [verilog/llm_pkg.sv]
// Purpose: constants for line supervision and mode control
// Assumes: Avalon-MM word addressing, 8-bit registers in low bits
// Notes: byte address is four times the register index
package llm_pkg;
    localparam logic [7:0] LLM_IDX_MODE = 8'h37;
    localparam logic [7:0] LLM_IDX_RECOV = 8'h39;
    localparam logic [7:0] LLM_IDX_DETECT = 8'h38;
    localparam logic [7:0] LLM_IDX_STATUS = 8'h3f;
    localparam logic [7:0] LLM_RST_MODE = 8'h80;
    localparam logic [7:0] LLM_RST_RECOV = 8'h00;
    localparam logic [7:0] LLM_RST_DETECT = 8'h00;
    localparam int LLM_BIT_CLEAR_ON_SIGNAL_LOSS = 7;
    localparam int LLM_BIT_THR_HI = 6;
    localparam int LLM_BIT_THR_LO = 4;
    localparam int LLM_BIT_LOOP_JITTER_ATTENUATE = 2;
    localparam int LLM_BIT_RLOOP = 1;
    localparam int LLM_BIT_DRS = 0;
    localparam logic [7:0] LLM_MODE_WMASK = 8'hf7;
    localparam int LLM_DET_SHIFT = 4;
    localparam int LLM_FIFO_DEPTH = 8;
    typedef enum logic [0:0] {
        LLM_ST_OK = 1'b0,
        LLM_ST_LOS = 1'b1
    } llm_los_t;
endpackage

// [verilog/llm_top.sv]
// Purpose: loss-of-signal supervision, data clearing, loop and rail select
// Assumes: receive clock arrives as a pin and is sampled, not used as a clock
// Notes: pulse positions are counted on sampled receive clock rising edges
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module llm_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    // clock
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic do_w;
    logic do_r;
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign do_w = clk_en && in_valid && in_ready;
    assign do_r = clk_en && out_valid && out_ready;
    assign out_data = mem_r[rp_r];
    always_ff @(posedge ref_clk) begin
        if (do_w) begin
            mem_r[wp_r] <= in_data;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (do_w) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (do_r) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            if (do_w && !do_r) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (do_r && !do_w) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////
module llm_top #(
    parameter int FIFO_DEPTH = llm_pkg::LLM_FIFO_DEPTH
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // line receive pins
    input wire logic rx_clk_pin,
    input wire logic analog_receive_line_pins,
    input wire logic analog_level_low,
    input wire logic receive_rail_positive,
    input wire logic receive_rail_negative,
    input wire logic bom_loop_request,
    // system receive data stream
    output logic rx_data_valid,
    input wire logic rx_data_ready,
    output logic rx_data,
    // system transmit data
    input wire logic tx_data,
    input wire logic dejitter_clk_ok,
    // line transmit side
    output logic analog_transmit_line_pins,
    output logic transmit_rail_positive,
    output logic transmit_rail_negative,
    output logic [2:0] input_threshold,
    output logic threshold_active,
    output logic loop_active,
    output logic loop_jitter_path,
    output logic loss_alarm
);
    import llm_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] mode_r;
    logic [7:0] recov_r;
    logic [7:0] detect_r;
    logic [31:0] rdata_r;
    logic rd_done_r;
    llm_los_t los_r;
    logic wr_lo;
    assign wr_lo = clk_en && avs_write && avs_byteenable[0];
    // reads take one extra cycle so read data come from a flop
    assign avs_waitrequest = avs_read && !rd_done_r;
    assign avs_readdata = rdata_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_r <= LLM_RST_MODE;
            recov_r <= LLM_RST_RECOV;
            detect_r <= LLM_RST_DETECT;
        end else if (wr_lo) begin
            if (avs_address == LLM_IDX_MODE) begin
                mode_r <= avs_writedata[7:0] & LLM_MODE_WMASK;
            end else if (avs_address == LLM_IDX_RECOV) begin
                recov_r <= avs_writedata[7:0];
            end else if (avs_address == LLM_IDX_DETECT) begin
                detect_r <= avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_r <= '0;
            rd_done_r <= 1'b0;
        end else if (clk_en) begin
            rd_done_r <= avs_read && !rd_done_r;
            if (avs_read && !rd_done_r) begin
                if (avs_address == LLM_IDX_MODE) begin
                    rdata_r <= {24'h000000, mode_r};
                end else if (avs_address == LLM_IDX_RECOV) begin
                    rdata_r <= {24'h000000, recov_r};
                end else if (avs_address == LLM_IDX_DETECT) begin
                    rdata_r <= {24'h000000, detect_r};
                end else if (avs_address == LLM_IDX_STATUS) begin
                    rdata_r <= {30'h00000000, loop_active, los_r == LLM_ST_LOS};
                end else begin
                    rdata_r <= '0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [4:0] s1_r;
    logic [4:0] s2_r;
    logic clk_d_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            clk_d_r <= 1'b0;
        end else if (clk_en) begin
            s1_r <= {rx_clk_pin, analog_receive_line_pins, analog_level_low,
                     receive_rail_positive, receive_rail_negative};
            s2_r <= s1_r;
            clk_d_r <= s2_r[4];
        end
    end

    logic dual_rail;
    logic pos_tick;
    logic pulse;
    logic rx_bit;
    logic level_low;
    assign dual_rail = mode_r[LLM_BIT_DRS];
    assign pos_tick = s2_r[4] && !clk_d_r;
    // rail mode pulses come from either digital rail, analog from the ternary slicer
    assign rx_bit = dual_rail ? (s2_r[1] | s2_r[0]) : s2_r[3];
    assign pulse = pos_tick && rx_bit;
    // digital rails carry no level, so only missing transitions count there
    assign level_low = dual_rail ? 1'b1 : s2_r[2];
    assign input_threshold = mode_r[LLM_BIT_THR_HI:LLM_BIT_THR_LO];
    assign threshold_active = !dual_rail;

    ////////////////////////////////////////////////////////////////////
    // loss detection and recovery
    logic [11:0] quiet_r;
    logic [11:0] win_r;
    logic [8:0] pcnt_r;
    logic win_open_r;
    logic [11:0] limit;
    assign limit = {detect_r, 4'hf}; // 16*(n+1)-1

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            los_r <= LLM_ST_OK;
            quiet_r <= '0;
            win_r <= '0;
            pcnt_r <= '0;
            win_open_r <= 1'b0;
        end else if (clk_en && pos_tick) begin
            case (los_r)
                LLM_ST_OK: begin
                    if (pulse) begin
                        quiet_r <= '0;
                    end else if (quiet_r == limit && level_low) begin
                        los_r <= LLM_ST_LOS;
                        quiet_r <= '0;
                        win_open_r <= 1'b0;
                        pcnt_r <= '0;
                    end else if (quiet_r != limit) begin
                        quiet_r <= quiet_r + 1'b1;
                    end
                end
                LLM_ST_LOS: begin
                    if (!win_open_r) begin
                        if (pulse) begin
                            win_open_r <= 1'b1;
                            win_r <= '0;
                            pcnt_r <= 9'h001;
                            if (recov_r == 8'h00) begin
                                los_r <= LLM_ST_OK;
                                win_open_r <= 1'b0;
                            end
                        end
                    end else if (pulse && pcnt_r >= {1'b0, recov_r}) begin
                        los_r <= LLM_ST_OK;
                        win_open_r <= 1'b0;
                        pcnt_r <= '0;
                    end else if (win_r == limit) begin
                        win_open_r <= 1'b0;
                        pcnt_r <= '0;
                    end else begin
                        win_r <= win_r + 1'b1;
                        if (pulse) begin
                            pcnt_r <= pcnt_r + 1'b1;
                        end
                    end
                end
                default: los_r <= LLM_ST_OK;
            endcase
        end
    end
    assign loss_alarm = (los_r == LLM_ST_LOS);

    ////////////////////////////////////////////////////////////////////
    // receive stream through fifo
    logic cleared_bit;
    logic fifo_ready;
    logic fifo_q;
    assign cleared_bit = (mode_r[LLM_BIT_CLEAR_ON_SIGNAL_LOSS] && loss_alarm) ? 1'b0 : rx_bit;
    // a full fifo drops bits: the line cannot be stalled
    llm_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(pos_tick),
        .in_ready(fifo_ready),
        .in_data(cleared_bit),
        .out_valid(rx_data_valid),
        .out_ready(rx_data_ready),
        .out_data(fifo_q)
    );
    assign rx_data = fifo_q;

    ////////////////////////////////////////////////////////////////////
    // loop and transmit path
    logic tx_src;
    logic tx_q_r;
    assign loop_active = mode_r[LLM_BIT_RLOOP] | bom_loop_request;
    // attenuator bit is masked outside remote loop
    assign loop_jitter_path = loop_active && mode_r[LLM_BIT_LOOP_JITTER_ATTENUATE];
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_q_r <= 1'b0;
        end else if (clk_en) begin
            if (!loop_active) begin
                tx_q_r <= tx_data;
            end else if (!loop_jitter_path) begin
                tx_q_r <= rx_bit;
            end else if (dejitter_clk_ok) begin
                tx_q_r <= rx_bit;
            end
        end
    end
    assign tx_src = tx_q_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            analog_transmit_line_pins <= 1'b0;
            transmit_rail_positive <= 1'b0;
            transmit_rail_negative <= 1'b0;
        end else if (clk_en) begin
            analog_transmit_line_pins <= dual_rail ? 1'b0 : tx_src;
            transmit_rail_positive <= dual_rail ? tx_src : 1'b0;
            transmit_rail_negative <= 1'b0;
        end
    end
    logic unused_ok;
    assign unused_ok = fifo_ready;
endmodule

// [tb/llm_properties.sv]
// Purpose: port-level checks of line supervision and mode control
// Assumes: bound to llm_top, single ref_clk domain
// Notes: register values are inferred from observed bus writes
`timescale 1ns/1ps

module llm_properties
    import llm_pkg::*;
(
    // clock and bus
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    // line and status
    input wire logic analog_level_low,
    input wire logic bom_loop_request,
    input wire logic [2:0] input_threshold,
    input wire logic threshold_active,
    input wire logic loop_active,
    input wire logic loop_jitter_path,
    input wire logic loss_alarm
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_wr_nowait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    chk_rd_onewait: assert property (avs_read && !$past(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read wait not one cycle");
    chk_mode_write: assert property (
        avs_write && clk_en && avs_byteenable[0] && avs_address == LLM_IDX_MODE |=>
        input_threshold == $past(avs_writedata[6:4]) && threshold_active == !$past(avs_writedata[0]))
        else $error("mode fields not taken");
    chk_be_ignore: assert property (avs_write && !avs_byteenable[0] |=> $stable(input_threshold)
        && $stable(threshold_active)) else $error("masked write took effect");
    chk_bom_loop: assert property (bom_loop_request |-> loop_active)
        else $error("message loop request ignored");
    chk_jit_loop: assert property (loop_jitter_path |-> loop_active)
        else $error("jitter path outside loop");
    chk_rst_clear: assert property ($past(rst) |-> !loss_alarm)
        else $error("alarm after reset");
    chk_hold_frozen: assert property (!clk_en |=> $stable(loss_alarm))
        else $error("alarm moved while frozen");
    chk_los_level: assert property ($rose(loss_alarm) && threshold_active |-> $past(analog_level_low, 2))
        else $error("alarm without low level");
endmodule

// [tb/llm_line_model.sv]
// Purpose: far-end line, recovered clock and mark stream
// Assumes: one position every 8 ref_clk cycles
// Notes: data moves mid high phase, far from the sampling edge
`timescale 1ns/1ps

module llm_line_model (
    // line side
    input wire logic ref_clk,
    input wire logic marks_on,
    output logic rx_clk_pin,
    output logic line_bit
);
    logic [1:0] ph_r = 2'h0;
    initial begin
        rx_clk_pin = 1'b0;
        line_bit = 1'b0;
    end
    // free-running line clock: a span carries timing even when empty
    always @(posedge ref_clk) begin
        ph_r <= ph_r + 2'h1;
        if (ph_r == 2'h3) rx_clk_pin <= ~rx_clk_pin;
        if (ph_r == 2'h1 && rx_clk_pin) line_bit <= marks_on;
    end
endmodule

// [tb/test_line_los_detect_and_loop_mode.sv]
// Purpose: self-checking bench for llm_top
// Assumes: line model drives the selected port, inverse on the other
// Notes: random mode writes, loss and recovery runs in both port modes
`timescale 1ns/1ps

module test_line_los_detect_and_loop_mode;
    import llm_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
    logic [7:0] avs_address = 8'h0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0] avs_byteenable = 4'h0;
    logic avs_waitrequest, rx_clk_pin, analog_receive_line_pins, analog_level_low = 1'b1;
    logic receive_rail_positive, receive_rail_negative, bom_loop_request = 1'b0;
    logic rx_data_valid, rx_data_ready = 1'b0, rx_data, tx_data = 1'b0, dejitter_clk_ok = 1'b0;
    logic analog_transmit_line_pins, transmit_rail_positive, transmit_rail_negative;
    logic [2:0] input_threshold;
    logic threshold_active, loop_active, loop_jitter_path, loss_alarm;
    logic marks_on = 1'b0, line_bit, dual_rail_select = 1'b0;
    logic [31:0] d;
    logic [1:0] hist = 2'h0;
    int miscompares = 0, n_tests = 0, ones = 0, seed = 32'hf8d4;

    llm_top u_llm_top (.*);
    llm_line_model u_llm_line_model (.ref_clk(ref_clk), .marks_on(marks_on), .rx_clk_pin(rx_clk_pin),
        .line_bit(line_bit));
    assign analog_receive_line_pins = dual_rail_select ? ~line_bit : line_bit;
    assign receive_rail_positive = dual_rail_select ? line_bit : ~line_bit;
    assign receive_rail_negative = ~dual_rail_select;

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        rx_data_ready <= $random(seed);
        tx_data <= $random(seed);
        dejitter_clk_ok <= $random(seed);
        // transmit pins lag the system bit by two edges
        hist <= {hist[0], tx_data};
        if (rx_data_valid === 1'b1 && rx_data_ready && loss_alarm === 1'b1) ones <= ones + rx_data;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until the rising edge that sees waitrequest low, data taken there
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd, input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= {24'h0, wd};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic los_run(input logic [7:0] m, input logic lvl, input logic exp);
        int n;
        bus(1, LLM_IDX_MODE, m, 4'h1);
        dual_rail_select <= m[0];
        analog_level_low <= lvl;
        marks_on <= 1'b1;
        repeat (40) @(posedge ref_clk);
        marks_on <= 1'b0;
        ones = 0;
        for (n = 0; n < 300 && loss_alarm !== 1'b1; n++) @(posedge ref_clk);
        check(loss_alarm, exp);
        if (exp) begin
            check(n >= 115 && n <= 165, 1);
            marks_on <= 1'b1;
            repeat (8) @(posedge ref_clk);
            marks_on <= 1'b0;
            repeat (200) @(posedge ref_clk);
            check(loss_alarm, 1);
            check(ones == 0, m[7]);
            marks_on <= 1'b1;
            for (n = 0; n < 60 && loss_alarm !== 1'b0; n++) @(posedge ref_clk);
            check(loss_alarm, 0);
        end
    endtask
    task automatic stop_test;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        stop_test;
    end
    initial begin
        logic [7:0] idx [5] = '{LLM_IDX_MODE, LLM_IDX_RECOV, LLM_IDX_DETECT, LLM_IDX_STATUS, 8'h10};
        logic [7:0] rv [5] = '{LLM_RST_MODE, LLM_RST_RECOV, LLM_RST_DETECT, 8'h00, 8'h00};
        logic [7:0] w;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 5; i++) begin
            bus(0, idx[i], 8'h0, 4'h1);
            check(d, {24'h0, rv[i]});
        end
        bus(1, 8'h10, 8'hff, 4'h1);
        bus(0, 8'h10, 8'h0, 4'h1);
        check(d, 0);
        for (int i = 0; i < 12; i++) begin
            w = (i == 0) ? 8'hff : $random(seed);
            bom_loop_request <= (i > 1) && $random(seed);
            bus(1, LLM_IDX_MODE, w, 4'h1);
            bus(1, LLM_IDX_MODE, ~w, 4'h0);
            bus(0, LLM_IDX_MODE, 8'h0, 4'h1);
            check(d, {24'h0, w & LLM_MODE_WMASK});
            check({input_threshold, threshold_active}, {w[6:4], !w[0]});
            check(loop_active, w[1] | bom_loop_request);
            check(loop_jitter_path, (w[1] | bom_loop_request) & w[2]);
            if (!(w[1] | bom_loop_request))
                check({analog_transmit_line_pins, transmit_rail_positive, transmit_rail_negative},
                    w[0] ? {1'b0, hist[1], 1'b0} : {hist[1], 2'b00});
            clk_en <= 1'b0;
            repeat (3) @(posedge ref_clk);
            clk_en <= 1'b1;
        end
        bom_loop_request <= 1'b0;
        bus(1, LLM_IDX_DETECT, 8'h00, 4'h1);
        bus(1, LLM_IDX_RECOV, 8'h01, 4'h1);
        los_run(8'h80, 1, 1);
        los_run(8'h00, 1, 1);
        los_run(8'h00, 0, 0);
        los_run(8'h81, 0, 1);
        stop_test;
    end
endmodule

bind llm_top llm_properties u_chk (.*);
